/* cfg_pin_pkg.sv */
// shared constants and types for the configuration pin handshake block
`default_nettype none
package cfg_pin_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0]  CTRL_OFFSET        = 8'h00;
    localparam logic [7:0]  FRAME_OFFSET       = 8'h04;
    localparam logic [7:0]  STATUS_OFFSET      = 8'h08;
    localparam logic [7:0]  RX_WORD_OFFSET     = 8'h0C;
    localparam logic [7:0]  TX_WORD_OFFSET     = 8'h10;

    // ****************************************
    // field positions
    // ****************************************
    localparam int          CTRL_MODE_LSB      = 0;
    localparam int          CTRL_WAIT_DONE_BIT = 2;
    localparam int          CTRL_ERROR_BIT     = 3;
    localparam int          CTRL_USER_PIN_BIT  = 4;
    localparam int          CTRL_USER_OE_BIT   = 5;
    localparam int          CTRL_RESTART_BIT   = 6;
    localparam int          FRAME_WORDS_LSB    = 0;
    localparam int          FRAME_COUNT_LSB    = 16;
    localparam int          STATUS_OVERRUN_BIT = 4;
    localparam int          WORD_W             = 32;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] FRAME_WORDS_RESET  = 16'h0004;
    localparam logic [15:0] FRAME_COUNT_RESET  = 16'h0002;

    // ****************************************
    // timing
    // ****************************************
    localparam int          CLK_PERIOD_NS      = 100;
    localparam int          POWER_SETTLE_NS    = 3200;
    localparam int          MEM_CLEAR_NS       = 6400;
    localparam logic [15:0] POWER_SETTLE_CYCLES =
        16'((POWER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] MEM_CLEAR_CYCLES   =
        16'((MEM_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************
    // bus answers and enumerations
    // ****************************************
    localparam logic [1:0]  AXI_OKAY           = 2'b00;
    localparam logic [1:0]  AXI_SLVERR         = 2'b10;

    typedef enum logic [1:0] {
        MODE_CLOCKED_SERIAL = 2'b00,
        MODE_SLAVE_SERIAL   = 2'b01,
        MODE_BYTE_WIDE      = 2'b10,
        MODE_FAST_PARALLEL  = 2'b11
    } mode_e;

    typedef enum logic [2:0] {
        ST_POWER   = 3'b000,
        ST_CLEAR   = 3'b001,
        ST_WAIT    = 3'b010,
        ST_LOAD    = 3'b011,
        ST_STARTUP = 3'b100,
        ST_USER    = 3'b101,
        ST_ABORT   = 3'b110
    } state_e;

endpackage
`default_nettype wire

/* config_pin_handshake_logic.sv */
// configuration pin control, word assembly and register slave
// ****************************************
// Behaviour
// - serial mode samples data on rising clock
// - data pin is parallel bit zero
// - data pin released after configuration unless user_oe set
// - completion pin low until configuration done
// - external low completion delays user activation
// - shared output driven while loading except in fast parallel mode
// - forwarded bit changes falling edge, 1.5 periods
// - shared pin: forward serial, busy byte-wide
// - busy high: bus data ignored, host holds
// - high indicator driven until user I/O
// - low indicator driven until user I/O
// - init low during settle and clear
// - external init low holds wait state
// - init low reports data error
// - init released once user I/O active
// - frames padded to whole 32-bit words
// - pad word follows every frame
// - pad frame first readback, last write
// - select high ignores clock in byte-wide
// - direction low writes; mid-word change aborts
// ****************************************
`timescale 1ns/1ps
`default_nettype none
module config_pin_handshake_logic
(
    input  wire logic                      CLK_IN,
    input  wire logic                      RST_B_IN,
    input  wire logic [7:0]                AXI_AWADDR_IN,
    input  wire logic                      AXI_AWVALID_IN,
    output logic                           AXI_AWREADY_OUT,
    input  wire logic [31:0]               AXI_WDATA_IN,
    input  wire logic [3:0]                AXI_WSTRB_IN,
    input  wire logic                      AXI_WVALID_IN,
    output logic                           AXI_WREADY_OUT,
    output logic [1:0]                     AXI_BRESP_OUT,
    output logic                           AXI_BVALID_OUT,
    input  wire logic                      AXI_BREADY_IN,
    input  wire logic [7:0]                AXI_ARADDR_IN,
    input  wire logic                      AXI_ARVALID_IN,
    output logic                           AXI_ARREADY_OUT,
    output logic [31:0]                    AXI_RDATA_OUT,
    output logic [1:0]                     AXI_RRESP_OUT,
    output logic                           AXI_RVALID_OUT,
    input  wire logic                      AXI_RREADY_IN,
    input  wire logic                      CONFIG_CLOCK_IN,
    input  wire logic                      SELECT_B_IN,
    input  wire logic                      DIRECTION_IN,
    input  wire logic                      PARALLEL_BIT_ZERO_IN,
    output logic                           PARALLEL_BIT_ZERO_OUT,
    output logic                           PARALLEL_BIT_ZERO_OE_OUT,
    input  wire logic [7:1]                PAR_DATA_IN,
    output logic [7:1]                     PAR_DATA_OUT,
    output logic                           PAR_DATA_OE_OUT,
    output logic                           SHARED_OUT,
    output logic                           SHARED_OE_OUT,
    input  wire logic                      DONE_IN,
    output logic                           DONE_OUT,
    output logic                           DONE_OE_OUT,
    input  wire logic                      INIT_B_IN,
    output logic                           INIT_B_OUT,
    output logic                           INIT_B_OE_OUT,
    output logic                           HIGH_WHILE_CONFIGURING_OUT,
    output logic                           HIGH_WHILE_CONFIGURING_OE_OUT,
    output logic                           LOW_WHILE_CONFIGURING_OUT,
    output logic                           LOW_WHILE_CONFIGURING_OE_OUT,
    output logic                           USER_IO_ENABLE_OUT,
    output logic [cfg_pin_pkg::WORD_W-1:0] RX_WORD_OUT
);
    import cfg_pin_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        state_e      state;
        logic [15:0] cnt;
        logic        clk_s1, clk_s2, clk_prev;
        logic        din_s1, din_s2;
        logic [7:1]  dat_s1, dat_s2;
        logic        sel_s1, sel_s2, dir_s1, dir_s2;
        logic        init_s1, init_s2, done_s1, done_s2;
        logic        stage1, stage2, fwd, busy;
        logic [31:0] shift;
        logic [4:0]  bitcnt;
        logic [1:0]  bytecnt;
        logic [31:0] rx_word;
        logic        rx_valid, overrun, dir_prev, dir_seen;
        logic [15:0] word_cnt, frame_cnt;
        logic [31:0] tx_word;
        logic        tx_valid, rb_pad;
        logic [1:0]  rb_bytes;
        logic [15:0] rb_words;
        logic [7:0]  rb_data;
        logic        rb_oe;
        mode_e       mode;
        logic        wait_done, report_error, user_pin, user_oe;
        logic [15:0] frame_words, frame_total;
        logic        awready, wready, aw_got, w_got;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready, rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        d0_out, d0_oe, shared_out, shared_oe, done_oe, init_oe, cfg_oe, user_en;
    } state_s;

    state_s r;
    state_s n;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic is_serial(input mode_e m);
        is_serial = (m == MODE_CLOCKED_SERIAL) || (m == MODE_SLAVE_SERIAL);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic        rise;
        logic        fall;
        logic        serial;
        logic        word_done;
        logic [31:0] wr_val;
        rise      = 1'b0;
        fall      = 1'b0;
        serial    = 1'b0;
        word_done = 1'b0;
        wr_val    = 32'h0000_0000;
        n         = r;

        // all pin inputs pass two flops before use
        n.clk_s1  = CONFIG_CLOCK_IN;
        n.clk_s2  = r.clk_s1;
        n.clk_prev = r.clk_s2;
        n.din_s1  = PARALLEL_BIT_ZERO_IN;
        n.din_s2  = r.din_s1;
        n.dat_s1  = PAR_DATA_IN;
        n.dat_s2  = r.dat_s1;
        n.sel_s1  = SELECT_B_IN;
        n.sel_s2  = r.sel_s1;
        n.dir_s1  = DIRECTION_IN;
        n.dir_s2  = r.dir_s1;
        n.init_s1 = INIT_B_IN;
        n.init_s2 = r.init_s1;
        n.done_s1 = DONE_IN;
        n.done_s2 = r.done_s1;
        rise      = r.clk_s2 & ~r.clk_prev;
        fall      = ~r.clk_s2 & r.clk_prev;
        serial    = is_serial(r.mode);

        // register write channel
        if (AXI_AWVALID_IN && r.awready)
        begin
            n.aw_got  = 1'b1;
            n.aw_addr = AXI_AWADDR_IN;
        end
        if (AXI_WVALID_IN && r.wready)
        begin
            n.w_got  = 1'b1;
            n.w_data = AXI_WDATA_IN;
            n.w_strb = AXI_WSTRB_IN;
        end
        if (r.bvalid && AXI_BREADY_IN)
        begin
            n.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bvalid)
        begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = AXI_OKAY;
            case (r.aw_addr)
                CTRL_OFFSET:
                begin
                    wr_val = merge({25'h0000000, 1'b0, r.user_oe, r.user_pin, r.report_error,
                                    r.wait_done, r.mode}, r.w_data, r.w_strb);
                    n.mode         = mode_e'(wr_val[CTRL_MODE_LSB +: 2]);
                    n.wait_done    = wr_val[CTRL_WAIT_DONE_BIT];
                    n.report_error = wr_val[CTRL_ERROR_BIT];
                    n.user_pin     = wr_val[CTRL_USER_PIN_BIT];
                    n.user_oe      = wr_val[CTRL_USER_OE_BIT];
                    if (wr_val[CTRL_RESTART_BIT])
                    begin
                        n.state = ST_CLEAR;
                        n.cnt   = 16'h0000;
                    end
                end
                FRAME_OFFSET:
                begin
                    wr_val = merge({r.frame_total, r.frame_words}, r.w_data, r.w_strb);
                    n.frame_words = wr_val[FRAME_WORDS_LSB +: 16];
                    n.frame_total = wr_val[FRAME_COUNT_LSB +: 16];
                end
                STATUS_OFFSET:
                begin
                    if (r.w_strb[0] && r.w_data[STATUS_OVERRUN_BIT])
                    begin
                        n.overrun = 1'b0;
                    end
                end
                TX_WORD_OFFSET:
                begin
                    n.tx_word  = merge(r.tx_word, r.w_data, r.w_strb);
                    n.tx_valid = 1'b1;
                end
                default:
                begin
                    n.bresp = AXI_SLVERR;
                end
            endcase
        end

        // register read channel
        if (r.rvalid && AXI_RREADY_IN)
        begin
            n.rvalid = 1'b0;
        end
        if (AXI_ARVALID_IN && r.arready)
        begin
            n.rvalid = 1'b1;
            n.rresp  = AXI_OKAY;
            case (AXI_ARADDR_IN)
                CTRL_OFFSET:    n.rdata = {25'h0000000, 1'b0, r.user_oe, r.user_pin,
                                           r.report_error, r.wait_done, r.mode};
                FRAME_OFFSET:   n.rdata = {r.frame_total, r.frame_words};
                STATUS_OFFSET:  n.rdata = {23'h000000, r.init_s2, r.done_s2, r.busy,
                                           r.tx_valid, r.overrun, r.rx_valid, r.state};
                RX_WORD_OFFSET:
                begin
                    n.rdata    = r.rx_word;
                    n.rx_valid = 1'b0;
                end
                default:
                begin
                    n.rdata = 32'h0000_0000;
                    n.rresp = AXI_SLVERR;
                end
            endcase
        end

        // sequence of the configuration flow
        case (r.state)
            ST_POWER:
            begin
                n.cnt = r.cnt + 16'h0001;
                if (r.cnt == POWER_SETTLE_CYCLES - 16'h0001)
                begin
                    n.state = ST_CLEAR;
                    n.cnt   = 16'h0000;
                end
            end
            ST_CLEAR:
            begin
                n.cnt = r.cnt + 16'h0001;
                if (r.cnt == MEM_CLEAR_CYCLES - 16'h0001)
                begin
                    n.state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (r.init_s2)
                begin
                    n.state     = ST_LOAD;
                    n.bitcnt    = 5'h00;
                    n.bytecnt   = 2'h0;
                    n.word_cnt  = 16'h0000;
                    n.frame_cnt = 16'h0000;
                    n.rb_pad    = 1'b1;
                    n.rb_words  = 16'h0000;
                    n.rb_bytes  = 2'h0;
                    n.dir_seen  = 1'b0;
                end
            end
            ST_LOAD:
            begin
                if (rise && serial)
                begin
                    n.stage1 = r.din_s2;
                    n.stage2 = r.stage1;
                    n.shift  = {r.shift[30:0], r.din_s2};
                    n.bitcnt = r.bitcnt + 5'h01;
                    word_done = (r.bitcnt == 5'h1F);
                end
                else if (rise && !r.sel_s2)
                begin
                    if (r.dir_seen && (r.dir_s2 != r.dir_prev) &&
                        ((r.bytecnt != 2'h0) || (r.rb_bytes != 2'h0)))
                    begin
                        n.state = ST_ABORT;
                    end
                    else
                    begin
                        n.dir_prev = r.dir_s2;
                        n.dir_seen = 1'b1;
                        if (!r.dir_s2 && !r.busy)
                        begin
                            n.shift   = {r.shift[23:0], r.dat_s2, r.din_s2};
                            n.bytecnt = r.bytecnt + 2'h1;
                            word_done = (r.bytecnt == 2'h3);
                        end
                        else if (r.dir_s2 && !r.busy && (r.mode == MODE_BYTE_WIDE))
                        begin
                            n.rb_oe    = 1'b1;
                            n.rb_data  = r.rb_pad ? 8'h00 : r.tx_word[(3 - r.rb_bytes)*8 +: 8];
                            n.rb_bytes = r.rb_bytes + 2'h1;
                            if (r.rb_bytes == 2'h3)
                            begin
                                if (r.rb_pad)
                                begin
                                    n.rb_words = r.rb_words + 16'h0001;
                                    n.rb_pad   = (r.rb_words != r.frame_words);
                                end
                                else
                                begin
                                    n.tx_valid = 1'b0;
                                end
                            end
                        end
                    end
                end
                if (fall && serial)
                begin
                    n.fwd = r.stage2;
                end
                if (word_done)
                begin
                    n.rx_word  = n.shift;
                    n.overrun  = n.overrun | n.rx_valid;
                    n.rx_valid = 1'b1;
                    n.word_cnt = r.word_cnt + 16'h0001;
                    if (r.word_cnt == r.frame_words)
                    begin
                        n.word_cnt  = 16'h0000;
                        n.frame_cnt = r.frame_cnt + 16'h0001;
                        if (r.frame_cnt == r.frame_total)
                        begin
                            n.state = ST_STARTUP;
                        end
                    end
                end
            end
            ST_STARTUP:
            begin
                if (!r.wait_done || r.done_s2)
                begin
                    n.state = ST_USER;
                end
            end
            ST_USER:
            begin
                n.cnt = 16'h0000;
            end
            ST_ABORT:
            begin
                n.cnt = 16'h0000;
            end
            default:
            begin
                n.state = ST_POWER;
            end
        endcase

        // pin drive from the new state
        if (n.state != ST_LOAD || r.sel_s2 || !r.dir_s2)
        begin
            n.rb_oe = 1'b0;
        end
        n.busy = (r.mode == MODE_BYTE_WIDE) && (n.state == ST_LOAD) &&
                 (r.dir_s2 ? (!n.rb_pad && !n.tx_valid) : n.rx_valid);
        n.shared_oe  = ((n.state == ST_LOAD) || (n.state == ST_STARTUP)) &&
                       (r.mode != MODE_FAST_PARALLEL);
        n.shared_out = is_serial(r.mode) ? n.fwd : n.busy;
        n.user_en    = (n.state == ST_USER);
        n.cfg_oe     = (n.state != ST_USER);
        n.done_oe    = (n.state != ST_USER) && (n.state != ST_STARTUP);
        n.init_oe    = (n.state == ST_POWER) || (n.state == ST_CLEAR) ||
                       (n.state == ST_ABORT) ||
                       ((n.state == ST_LOAD) && r.report_error);
        n.d0_oe      = (n.state == ST_USER) ? r.user_oe : n.rb_oe;
        n.d0_out     = (n.state == ST_USER) ? r.user_pin : n.rb_data[0];
        n.awready    = !n.aw_got && !n.bvalid;
        n.wready     = !n.w_got && !n.bvalid;
        n.arready    = !n.rvalid;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            r             <= '0;
            r.state       <= ST_POWER;
            r.mode        <= MODE_CLOCKED_SERIAL;
            r.frame_words <= FRAME_WORDS_RESET;
            r.frame_total <= FRAME_COUNT_RESET;
            r.init_oe     <= 1'b1;
            r.done_oe     <= 1'b1;
            r.cfg_oe      <= 1'b1;
            r.clk_s1      <= 1'b1;
            r.clk_s2      <= 1'b1;
            r.clk_prev    <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign AXI_AWREADY_OUT               = r.awready;
    assign AXI_WREADY_OUT                = r.wready;
    assign AXI_BRESP_OUT                 = r.bresp;
    assign AXI_BVALID_OUT                = r.bvalid;
    assign AXI_ARREADY_OUT               = r.arready;
    assign AXI_RDATA_OUT                 = r.rdata;
    assign AXI_RRESP_OUT                 = r.rresp;
    assign AXI_RVALID_OUT                = r.rvalid;
    assign PARALLEL_BIT_ZERO_OUT         = r.d0_out;
    assign PARALLEL_BIT_ZERO_OE_OUT      = r.d0_oe;
    assign PAR_DATA_OUT                  = r.rb_data[7:1];
    assign PAR_DATA_OE_OUT               = r.rb_oe;
    assign SHARED_OUT                    = r.shared_out;
    assign SHARED_OE_OUT                 = r.shared_oe;
    assign DONE_OUT                      = 1'b0;
    assign DONE_OE_OUT                   = r.done_oe;
    assign INIT_B_OUT                    = 1'b0;
    assign INIT_B_OE_OUT                 = r.init_oe;
    assign HIGH_WHILE_CONFIGURING_OUT    = r.cfg_oe;
    assign HIGH_WHILE_CONFIGURING_OE_OUT = r.cfg_oe;
    assign LOW_WHILE_CONFIGURING_OUT     = 1'b0;
    assign LOW_WHILE_CONFIGURING_OE_OUT  = r.cfg_oe;
    assign USER_IO_ENABLE_OUT            = r.user_en;
    assign RX_WORD_OUT                   = r.rx_word;

endmodule
`default_nettype wire

/* cfg_pin_sva.sv */
// assertions on the configuration pin handshake block
`timescale 1ns/1ps
`default_nettype none
module cfg_pin_sva
(
    input  wire logic CLK_IN,
    input  wire logic RST_B_IN,
    input  wire logic INIT_B_IN,
    input  wire logic INIT_B_OE_OUT,
    input  wire logic DONE_OE_OUT,
    input  wire logic HIGH_WHILE_CONFIGURING_OE_OUT,
    input  wire logic LOW_WHILE_CONFIGURING_OE_OUT,
    input  wire logic USER_IO_ENABLE_OUT,
    input  wire logic SHARED_OE_OUT,
    input  wire logic AXI_ARREADY_OUT,
    input  wire logic AXI_RVALID_OUT
);
    // ****
    // pin and read channel checks
    // ****
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    init_power_a: assert property ($rose(RST_B_IN) |-> INIT_B_OE_OUT[*8])
        else $error("init not held low after reset");
    wait_hold_a: assert property (!INIT_B_IN && !SHARED_OE_OUT |=> !SHARED_OE_OUT)
        else $error("load began with init low");
    high_release_a: assert property (USER_IO_ENABLE_OUT |-> !HIGH_WHILE_CONFIGURING_OE_OUT)
        else $error("high indicator still driven");
    low_release_a: assert property (USER_IO_ENABLE_OUT |-> !LOW_WHILE_CONFIGURING_OE_OUT)
        else $error("low indicator still driven");
    init_release_a: assert property (USER_IO_ENABLE_OUT |-> !INIT_B_OE_OUT)
        else $error("init still driven in user mode");
    done_first_a: assert property ($rose(USER_IO_ENABLE_OUT) |-> !$past(DONE_OE_OUT))
        else $error("user mode before completion");
    shared_idle_a: assert property (USER_IO_ENABLE_OUT |-> !SHARED_OE_OUT)
        else $error("shared pin driven in user mode");
    read_answer_a: assert property ($fell(AXI_ARREADY_OUT) |-> AXI_RVALID_OUT)
        else $error("read answer late");
endmodule
bind config_pin_handshake_logic cfg_pin_sva u_sva
(
    .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .INIT_B_IN(INIT_B_IN), .INIT_B_OE_OUT(INIT_B_OE_OUT),
    .DONE_OE_OUT(DONE_OE_OUT), .HIGH_WHILE_CONFIGURING_OE_OUT(HIGH_WHILE_CONFIGURING_OE_OUT),
    .LOW_WHILE_CONFIGURING_OE_OUT(LOW_WHILE_CONFIGURING_OE_OUT),
    .USER_IO_ENABLE_OUT(USER_IO_ENABLE_OUT), .SHARED_OE_OUT(SHARED_OE_OUT),
    .AXI_ARREADY_OUT(AXI_ARREADY_OUT), .AXI_RVALID_OUT(AXI_RVALID_OUT)
);
`default_nettype wire

/* cfg_host.sv */
// model of the configuration host on the serial link
`timescale 1ns/1ps
`default_nettype none
module cfg_host
(
    output logic link_clk_out,
    output logic link_bit_out
);
    // ****
    // link driver
    // ****
    initial link_clk_out = 1'b0;
    initial link_bit_out = 1'b0;
    // msb first, one bit per 800 ns rise, clock idle between words
    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            link_bit_out <= w[i];
            #400 link_clk_out <= 1'b1;
            #400 link_clk_out <= 1'b0;
        end
        link_bit_out <= ~w[0];
        #400;
    endtask
endmodule
`default_nettype wire

/* config_pin_handshake_logic_tb.sv */
// self-checking bench for the configuration pin handshake block
`timescale 1ns/1ps
`default_nettype none
module config_pin_handshake_logic_tb;
    import cfg_pin_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, hold_init = 1'b1, hold_done = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rx_word;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, init_oe, done_oe, hi_oe, lo_oe, user_en;
    logic        sh_oe, b0_oe, link_clk, link_bit;
    int          n_mismatch = 0, comparisons = 0;
    wire         done_w = !(done_oe || hold_done);
    wire         init_w = !(init_oe || hold_init);
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    cfg_host host (.link_clk_out(link_clk), .link_bit_out(link_bit));
    config_pin_handshake_logic dut
    (
        .CLK_IN(clk), .RST_B_IN(rst_b), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
        .AXI_AWREADY_OUT(aw_rdy), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb),
        .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(w_rdy), .AXI_BRESP_OUT(bresp),
        .AXI_BVALID_OUT(b_v), .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr),
        .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(ar_rdy), .AXI_RDATA_OUT(rdata),
        .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(r_v), .AXI_RREADY_IN(rready),
        .CONFIG_CLOCK_IN(link_clk), .SELECT_B_IN(1'b1), .DIRECTION_IN(1'b0),
        .PARALLEL_BIT_ZERO_IN(link_bit), .PARALLEL_BIT_ZERO_OUT(),
        .PARALLEL_BIT_ZERO_OE_OUT(b0_oe), .PAR_DATA_IN(7'h00), .PAR_DATA_OUT(),
        .PAR_DATA_OE_OUT(), .SHARED_OUT(), .SHARED_OE_OUT(sh_oe), .DONE_IN(done_w),
        .DONE_OUT(), .DONE_OE_OUT(done_oe), .INIT_B_IN(init_w), .INIT_B_OUT(),
        .INIT_B_OE_OUT(init_oe), .HIGH_WHILE_CONFIGURING_OUT(),
        .HIGH_WHILE_CONFIGURING_OE_OUT(hi_oe), .LOW_WHILE_CONFIGURING_OUT(),
        .LOW_WHILE_CONFIGURING_OE_OUT(lo_oe), .USER_IO_ENABLE_OUT(user_en), .RX_WORD_OUT(rx_word)
    );
    // ****
    // helpers
    // ****
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (aw_rdy === 1'b1) awvalid <= 1'b0;
            if (w_rdy === 1'b1) wvalid <= 1'b0;
        end
        while (b_v !== 1'b1);
        bready <= 1'b0;
        chk(b_v === 1'b1 && bresp === AXI_OKAY, "write resp");
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (ar_rdy === 1'b1) arvalid <= 1'b0;
        end
        while (r_v !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk(r_v === 1'b1 && rresp === r, "read resp");
        @(posedge clk);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        logic [31:0] d;
        chk(init_oe === 1'b1 && hi_oe === 1'b1 && lo_oe === 1'b1, "pre config");
        chk(user_en === 1'b0 && done_oe === 1'b1, "not done");
        axr(FRAME_OFFSET, d, AXI_OKAY);
        chk(d === {FRAME_COUNT_RESET, FRAME_WORDS_RESET}, "frame reset");
        axw(FRAME_OFFSET, 32'hFFFF_0003, 4'h3);
        axr(FRAME_OFFSET, d, AXI_OKAY);
        chk(d === {FRAME_COUNT_RESET, 16'h0003}, "frame strobe");
        axr(8'h14, d, AXI_SLVERR);
        chk(d === 32'h0, "unmapped");
    endtask
    task automatic t_wait();
        logic [31:0] d;
        axw(CTRL_OFFSET, 32'h0000_0004, 4'hF);
        axw(FRAME_OFFSET, 32'h0001_0001, 4'hF);
        repeat (150) @(posedge clk);
        axr(STATUS_OFFSET, d, AXI_OKAY);
        chk(d[2:0] === ST_WAIT, "init hold");
        hold_init <= 1'b0;
        repeat (8) @(posedge clk);
        axr(STATUS_OFFSET, d, AXI_OKAY);
        chk(d[2:0] === ST_LOAD && sh_oe === 1'b1, "load");
    endtask
    task automatic t_load();
        logic [31:0] d;
        host.send_word(32'hA5C3_0F1E);
        repeat (6) @(posedge clk);
        axr(RX_WORD_OFFSET, d, AXI_OKAY);
        chk(d === 32'hA5C3_0F1E && rx_word === 32'hA5C3_0F1E, "rx word");
        repeat (3) host.send_word(32'h0000_0000);
        repeat (20) @(posedge clk);
        chk(user_en === 1'b0 && done_oe === 1'b0, "done hold");
        hold_done <= 1'b0;
        repeat (20) @(posedge clk);
        chk(user_en === 1'b1 && init_oe === 1'b0 && hi_oe === 1'b0, "user");
        chk(lo_oe === 1'b0 && b0_oe === 1'b0 && sh_oe === 1'b0, "release");
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_wait();
        t_load();
        results();
    end
    initial
    begin
        #(4000 * CLK_PERIOD_NS);
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
